/* rtl/tmc_pkg.sv */
// Package for the timer/compare block: register map, fields, modes, reset values
`default_nettype none
package tmc_pkg;
    // Register byte addresses on the AXI4-Lite slave
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_COUNT = 4'h4;
    localparam logic [3:0] ADDR_COMPARE = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;
    // Control field positions
    localparam int FORCE_BIT = 7;
    localparam int WAVE_LO_BIT = 6;
    localparam int ACTION_HI_BIT = 5;
    localparam int ACTION_LO_BIT = 4;
    localparam int WAVE_HI_BIT = 3;
    localparam int CLKSEL_MSB = 2;
    // Status field positions (sticky, write one to clear)
    localparam int STAT_COMPARE_BIT = 0;
    localparam int STAT_OVERFLOW_BIT = 1;
    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    // Counter limits
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    // Prescaler width for the largest divide ratio of 1024
    localparam int PRESC_W = 10;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Waveform modes
    typedef enum logic [1:0] {
        WAVE_NORMAL = 2'h0,
        WAVE_PHASE = 2'h1,
        WAVE_CLEAR_ON_MATCH = 2'h2,
        WAVE_FAST = 2'h3
    } tmc_wave_e;
endpackage
`default_nettype wire

/* rtl/tmc_prescaler.sv */
// Prescaler turning the source clock enable into the divided timer tick
`default_nettype none
module tmc_prescaler (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Source enable and selection
    input wire logic src_en,
    input wire logic [2:0] clock_select,
    // Tick out
    output logic timer_tick
);
    logic [tmc_pkg::PRESC_W-1:0] div_ff;
    logic [tmc_pkg::PRESC_W-1:0] nxt_div;
    logic [tmc_pkg::PRESC_W-1:0] mask;

    // Free running divider, advanced only on source ticks
    assign nxt_div = div_ff + 10'h001;

    always_ff @(posedge core_clk)
    begin
        if (rst)
            div_ff <= 10'h000;
        else if (src_en)
            div_ff <= nxt_div;
    end

    // Low bits of the divider that must be all ones for each ratio
    always_comb
    begin
        unique case (clock_select)
            3'h2: mask = 10'h007;
            3'h3: mask = 10'h01F;
            3'h4: mask = 10'h03F;
            3'h5: mask = 10'h07F;
            3'h6: mask = 10'h0FF;
            3'h7: mask = 10'h3FF;
            default: mask = 10'h000;
        endcase
    end

    // Code 0 stops; code 1 passes every source tick
    assign timer_tick = src_en && (clock_select != 3'h0) &&
        ((div_ff & mask) == mask); // RULE14
endmodule
`default_nettype wire

/* rtl/tmc_timer.sv */
// 8-bit timer/counter with one compare channel behind an AXI4-Lite slave
// Functional notes
// [RULE1] Timer tick is a clock enable; async oscillator tick may replace I/O tick.
// [RULE2] Writing force bit in non-PWM mode applies a match to the output at once.
// [RULE3] Forced match sets no compare flag and never clears the counter.
// [RULE4] Force bit is a write-only strobe, reads zero, effective only outside PWM.
// [RULE5] Software writes force bit as zero while a PWM mode is selected.
// [RULE6] Mode field at bits 6 and 3: normal, phase PWM, clear-on-match, fast PWM.
// [RULE7] TOP is 0xFF or compare; compare buffered to TOP in PWM; overflow per mode.
// [RULE8] Clear-on-match mode: match sets compare flag and clears the counter.
// [RULE9] Nonzero action field takes over the pin; software still enables direction.
// [RULE10] Non-PWM action: disconnect, toggle, clear, set on match.
// [RULE11] Fast PWM action: disconnect, reserved, clear/set at TOP, set/clear at TOP.
// [RULE12] Phase PWM action: clear up, set down; or the opposite.
// [RULE13] PWM with compare at TOP and action high bit: match ignored, act at TOP.
// [RULE14] Clock select: stop, undivided, then 8, 32, 64, 128, 256, 1024.
// [RULE15] Counter register is readable and writable by software.
// [RULE16] Counter write blocks compare match on the next timer tick.
// [RULE17] Compare register checked each tick; match sets flag and drives output.
// [RULE18] Fast PWM counts bottom to max then wraps to bottom.
// [RULE19] Phase PWM counts up to max then down to bottom repeatedly.
// [RULE20] Phase PWM holds max for exactly one tick at the turn.
// [RULE21] Reset zeroes control, counter and compare: stopped, output disconnected.
`default_nettype none
module tmc_timer (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Timer source: async oscillator tick and selector
    input wire logic osc_tick,
    input wire logic async_sel,
    // AXI4-Lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Compare pin
    output logic compare_out_pin,
    output logic pin_override
);
    logic [7:0] ctrl_ff;
    logic [7:0] count_ff;
    logic [7:0] cmp_ff;
    logic [7:0] cmp_buf_ff;
    logic down_ff;
    logic oc_ff;
    logic block_ff;
    logic [1:0] stat_ff;
    logic aw_hold_ff;
    logic w_hold_ff;
    logic [3:0] awaddr_ff;
    logic [7:0] wdata_ff;
    logic wstrb0_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    // Control field decode
    wire [1:0] wave_mode = {ctrl_ff[tmc_pkg::WAVE_HI_BIT], ctrl_ff[tmc_pkg::WAVE_LO_BIT]}; // RULE6
    wire [1:0] out_action = {ctrl_ff[tmc_pkg::ACTION_HI_BIT], ctrl_ff[tmc_pkg::ACTION_LO_BIT]};
    wire [2:0] clock_select = ctrl_ff[tmc_pkg::CLKSEL_MSB:0];
    wire is_fast = wave_mode == tmc_pkg::WAVE_FAST;
    wire is_phase = wave_mode == tmc_pkg::WAVE_PHASE;
    wire is_clr_match = wave_mode == tmc_pkg::WAVE_CLEAR_ON_MATCH;
    wire is_pwm = is_fast || is_phase;

    // Source tick: async oscillator takes the core clock's place
    wire src_en = async_sel ? osc_tick : 1'b1; // RULE1
    wire timer_tick;

    tmc_prescaler u_presc (
        .core_clk(core_clk),
        .rst(rst),
        .src_en(src_en),
        .clock_select(clock_select),
        .timer_tick(timer_tick)
    );

    // Write path: address and data taken in either order, held until both present
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire have_aw = aw_hold_ff || aw_take;
    wire have_w = w_hold_ff || w_take;
    wire wr_fire = have_aw && have_w && !bvalid_ff;
    wire [3:0] wr_addr = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
    wire [7:0] wr_data = w_hold_ff ? wdata_ff : s_axi_wdata[7:0];
    wire wr_lane0 = w_hold_ff ? wstrb0_ff : s_axi_wstrb[0];
    wire wr_ctrl = wr_fire && wr_lane0 && wr_addr == tmc_pkg::ADDR_CONTROL;
    wire wr_count = wr_fire && wr_lane0 && wr_addr == tmc_pkg::ADDR_COUNT;
    wire wr_cmp = wr_fire && wr_lane0 && wr_addr == tmc_pkg::ADDR_COMPARE;
    wire wr_stat = wr_fire && wr_lane0 && wr_addr == tmc_pkg::ADDR_STATUS;
    wire wr_known = wr_addr == tmc_pkg::ADDR_CONTROL || wr_addr == tmc_pkg::ADDR_COUNT ||
        wr_addr == tmc_pkg::ADDR_COMPARE || wr_addr == tmc_pkg::ADDR_STATUS;
    assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
    assign s_axi_wready = !w_hold_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // Force strobe judged on the written mode and action, as software sets them together
    wire force_hit = wr_ctrl && wr_data[tmc_pkg::FORCE_BIT] &&
        !wr_data[tmc_pkg::WAVE_LO_BIT]; // RULE2 RULE4 RULE5

    // Effective TOP and compare: PWM uses the buffer loaded at TOP
    wire [7:0] cmp_eff = is_pwm ? cmp_buf_ff : cmp_ff;
    wire [7:0] top_val = is_clr_match ? cmp_ff : tmc_pkg::CNT_MAX; // RULE7
    wire at_top = count_ff == top_val;
    wire raw_match = timer_tick && !block_ff && count_ff == cmp_eff; // RULE16 RULE17
    // Compare at TOP with action high bit: match ignored, TOP action instead
    wire top_special = is_pwm && out_action[1] && cmp_eff == tmc_pkg::CNT_MAX; // RULE13
    wire match = raw_match && !top_special;
    wire phase_turn_up = is_phase && count_ff == tmc_pkg::CNT_MAX;

    // Next count per mode
    logic [7:0] nxt_count;
    logic nxt_down;
    always_comb
    begin
        nxt_count = count_ff;
        nxt_down = down_ff;
        if (timer_tick)
        begin
            if (is_phase)
            begin
                if (!down_ff && count_ff == tmc_pkg::CNT_MAX)
                begin
                    nxt_down = 1'b1; // RULE20
                    nxt_count = count_ff - 8'h01;
                end
                else if (down_ff && count_ff == tmc_pkg::CNT_BOTTOM)
                begin
                    nxt_down = 1'b0; // RULE19
                    nxt_count = count_ff + 8'h01;
                end
                else
                    nxt_count = down_ff ? count_ff - 8'h01 : count_ff + 8'h01;
            end
            else if (is_clr_match && at_top && !block_ff)
                nxt_count = tmc_pkg::CNT_BOTTOM; // RULE8
            else
                nxt_count = count_ff + 8'h01; // RULE18
        end
    end

    // Overflow: at MAX except phase mode, which flags at BOTTOM
    wire ovf_hit = timer_tick && (is_phase ? (down_ff && count_ff == tmc_pkg::CNT_BOTTOM)
        : count_ff == tmc_pkg::CNT_MAX); // RULE7

    // Waveform output next value
    logic nxt_oc;
    always_comb
    begin
        nxt_oc = oc_ff;
        if (force_hit || (match && !is_pwm))
        begin
            unique case (force_hit ? wr_data[tmc_pkg::ACTION_HI_BIT -: 2] : out_action) // RULE10
                2'h1: nxt_oc = !oc_ff;
                2'h2: nxt_oc = 1'b0;
                2'h3: nxt_oc = 1'b1;
                default: nxt_oc = oc_ff;
            endcase
        end
        else if (is_fast && out_action[1])
        begin
            if (match)
                nxt_oc = out_action[0]; // RULE11
            else if (timer_tick && count_ff == tmc_pkg::CNT_MAX)
                nxt_oc = !out_action[0]; // RULE11 RULE13
        end
        else if (is_phase && out_action[1])
        begin
            if (match)
                nxt_oc = down_ff ? !out_action[0] : out_action[0]; // RULE12
            else if (timer_tick && phase_turn_up && top_special)
                nxt_oc = !out_action[0]; // RULE13
        end
    end

    // Counter, direction and block of the next match
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            count_ff <= tmc_pkg::COUNT_RESET; // RULE21
            down_ff <= 1'b0;
            block_ff <= 1'b0;
        end
        else if (wr_count)
        begin
            count_ff <= wr_data; // RULE15
            block_ff <= 1'b1; // RULE16
        end
        else
        begin
            count_ff <= nxt_count;
            down_ff <= is_phase ? nxt_down : 1'b0;
            if (timer_tick)
                block_ff <= 1'b0;
        end
    end

    // Control, compare and its TOP-loaded buffer; force bit never stored
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ctrl_ff <= tmc_pkg::CONTROL_RESET; // RULE21
            cmp_ff <= tmc_pkg::COMPARE_RESET;
            cmp_buf_ff <= tmc_pkg::COMPARE_RESET;
            oc_ff <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_ff <= {1'b0, wr_data[6:0]}; // RULE4
            if (wr_cmp)
                cmp_ff <= wr_data;
            // Double buffer hides glitches mid-period in PWM
            if (!is_pwm || (timer_tick && count_ff == tmc_pkg::CNT_MAX))
                cmp_buf_ff <= cmp_ff; // RULE7
            oc_ff <= nxt_oc;
        end
    end

    // Sticky status; hardware set beats software clear; forced match sets nothing
    wire [1:0] stat_set = {ovf_hit, match}; // RULE3 RULE17
    always_ff @(posedge core_clk)
    begin
        if (rst)
            stat_ff <= 2'h0;
        else
            stat_ff <= (stat_ff & ~(wr_stat ? wr_data[1:0] : 2'h0)) | stat_set;
    end

    // Write channel holding and response
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= 4'h0;
            wdata_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= tmc_pkg::RESP_OKAY;
        end
        else
        begin
            if (aw_take)
                awaddr_ff <= s_axi_awaddr;
            if (w_take)
            begin
                wdata_ff <= s_axi_wdata[7:0];
                wstrb0_ff <= s_axi_wstrb[0];
            end
            aw_hold_ff <= have_aw && !wr_fire;
            w_hold_ff <= have_w && !wr_fire;
            if (wr_fire)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_known ? tmc_pkg::RESP_OKAY : tmc_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_ff <= 1'b0;
        end
    end

    // Read decode; force bit always reads zero
    wire rd_take = s_axi_arvalid && s_axi_arready;
    logic [31:0] rd_word;
    logic rd_ok;
    always_comb
    begin
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            tmc_pkg::ADDR_CONTROL: rd_word = {24'h000000, 1'b0, ctrl_ff[6:0]}; // RULE4
            tmc_pkg::ADDR_COUNT: rd_word = {24'h000000, count_ff}; // RULE15
            tmc_pkg::ADDR_COMPARE: rd_word = {24'h000000, cmp_ff};
            tmc_pkg::ADDR_STATUS: rd_word = {30'h00000000, stat_ff};
            default:
            begin
                rd_word = 32'h00000000;
                rd_ok = 1'b0;
            end
        endcase
    end
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= tmc_pkg::RESP_OKAY;
        end
        else if (rd_take)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= rd_ok ? tmc_pkg::RESP_OKAY : tmc_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_ff <= 1'b0;
    end

    // Pin takeover whenever either action bit is set
    assign compare_out_pin = oc_ff;
    assign pin_override = out_action != 2'h0; // RULE9

    // Forced match leaves counter and flag untouched in clear-on-match mode
    force_quiet_a: assert property (@(posedge core_clk) disable iff (rst) // RULE3
        (force_hit && !timer_tick && !wr_count) |=> (count_ff == $past(count_ff)) &&
        !(stat_ff[0] && !$past(stat_ff[0])))
        else $error("forced match changed counter or flag");
    force_reads_a: assert property (@(posedge core_clk) disable iff (rst) // RULE4
        ctrl_ff[tmc_pkg::FORCE_BIT] == 1'b0)
        else $error("force bit stored");
    match_clear_a: assert property (@(posedge core_clk) disable iff (rst) // RULE8
        (is_clr_match && timer_tick && at_top && !block_ff && !wr_count && !wr_ctrl)
        |=> count_ff == 8'h00 && stat_ff[0])
        else $error("clear-on-match did not clear");
    block_next_a: assert property (@(posedge core_clk) disable iff (rst) // RULE16
        wr_count |=> block_ff && !match)
        else $error("match after counter write");
    sequence up_to_max;
        is_phase && timer_tick && !down_ff && count_ff == 8'hFF;
    endsequence
    phase_turn_a: assert property (@(posedge core_clk) disable iff (rst) // RULE20
        (up_to_max and !wr_count and !wr_ctrl) |=> down_ff && count_ff == 8'hFE)
        else $error("phase turn wrong");
    fast_wrap_a: assert property (@(posedge core_clk) disable iff (rst) // RULE18
        (is_fast && timer_tick && count_ff == 8'hFF && !wr_count && !wr_ctrl)
        |=> count_ff == 8'h00 && stat_ff[1])
        else $error("fast wrap wrong");
    stopped_a: assert property (@(posedge core_clk) disable iff (rst) // RULE14
        (clock_select == 3'h0 && !wr_count) |=> $stable(count_ff))
        else $error("counter ran while stopped");
    override_a: assert property (@(posedge core_clk) disable iff (rst) // RULE9
        pin_override == (ctrl_ff[5:4] != 2'h0))
        else $error("pin override wrong");
    pwm_match_a: assert property (@(posedge core_clk) disable iff (rst) // RULE11 RULE12
        (is_pwm && out_action[1] && match && !wr_ctrl)
        |=> compare_out_pin == ($past(out_action[0]) ^ $past(is_phase && down_ff)))
        else $error("PWM match drove the wrong pin level");
endmodule
`default_nettype wire

/* testbench/tb_tmc_timer.sv */
// Self-checking bench for the timer/compare block over AXI4-Lite
`default_nettype none
module tb_tmc_timer;
    timeunit 1ns;
    timeprecision 1ps;
    // Clock, reset and timer source
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic osc_tick = 1'b0;
    logic async_sel = 1'b0;
    logic [1:0] osc_div = 2'h0;
    // Master side of the register bus
    logic [3:0] s_axi_awaddr = 4'h0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic compare_out_pin, pin_override;
    // Bookkeeping and scenario tables
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    int hi, tg;
    logic [31:0] d;
    int divs [8] = '{1, 8, 32, 64, 128, 256, 1024, 4};
    logic [7:0] fctl [4] = '{8'hB0, 8'h90, 8'h90, 8'hA0};
    logic fpin [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic [7:0] pctl [6] = '{8'h69, 8'h69, 8'h79, 8'h61, 8'h61, 8'h71};
    logic [7:0] pcmp [6] = '{8'h40, 8'hFF, 8'h40, 8'h40, 8'hFF, 8'h40};
    int pwin [6] = '{512, 512, 512, 1020, 1020, 1020};
    int phi [6] = '{130, 512, 382, 256, 1020, 764};
    int ptol [6] = '{4, 0, 4, 6, 0, 6};

    tmc_timer dut (
        .core_clk(core_clk), .rst(rst), .osc_tick(osc_tick), .async_sel(async_sel),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .compare_out_pin(compare_out_pin), .pin_override(pin_override)
    );

    // Free-running core clock
    always #4 core_clk = ~core_clk;

    // Oscillator stand-in: one-cycle pulse every fourth core cycle
    always @(posedge core_clk)
    begin
        osc_div <= osc_div + 2'h1;
        osc_tick <= (osc_div == 2'h3);
    end

    // Hang guard, well above the roughly 35000 cycles the tests need
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Range compare; the window absorbs prescaler phase and bus latency
    task automatic near(input int got, input int exp, input int tol);
        chk((got >= exp - tol && got <= exp + tol) ? 32'(exp) : 32'(got), 32'(exp));
    endtask

    // Bus write: both channels offered together, each dropped once taken
    task automatic wr(input logic [3:0] a, input logic [31:0] v,
            input logic [1:0] er = tmc_pkg::RESP_OKAY);
        logic got;
        got = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!got)
        begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1)
            begin
                got = 1'b1;
                s_axi_bready <= 1'b0;
                chk({30'h0, s_axi_bresp}, {30'h0, er});
            end
        end
    endtask

    // Bus read; data kept in d, masked field compared with the expectation
    task automatic rd(input logic [3:0] a, input logic [31:0] e,
            input logic [31:0] m = 32'hFFFFFFFF, input logic [1:0] er = tmc_pkg::RESP_OKAY);
        logic got;
        got = 1'b0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!got)
        begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
            begin
                got = 1'b1;
                d = s_axi_rdata;
                s_axi_rready <= 1'b0;
                chk(s_axi_rdata & m, e);
                chk({30'h0, s_axi_rresp}, {30'h0, er});
            end
        end
    endtask

    // Pin high time and edge count over n cycles
    task automatic measure(input int n);
        logic p;
        hi = 0;
        tg = 0;
        @(posedge core_clk);
        p = compare_out_pin;
        repeat (n)
        begin
            @(posedge core_clk);
            hi += int'(compare_out_pin === 1'b1);
            tg += int'(compare_out_pin !== p);
            p = compare_out_pin;
        end
    endtask

    // Test sequence
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        chk({30'h0, pin_override, compare_out_pin}, 32'h0);
        rd(tmc_pkg::ADDR_CONTROL, 32'h0);
        rd(tmc_pkg::ADDR_COUNT, 32'h0);
        rd(tmc_pkg::ADDR_COMPARE, 32'h0);
        rd(tmc_pkg::ADDR_STATUS, 32'h0);
        rd(4'h2, 32'h0, 32'hFFFFFFFF, tmc_pkg::RESP_SLVERR);
        $display("test reset done");
        wr(tmc_pkg::ADDR_COUNT, 32'h5A);
        wr(tmc_pkg::ADDR_CONTROL, 32'h88);
        rd(tmc_pkg::ADDR_CONTROL, 32'h08);
        repeat (40) @(posedge core_clk);
        rd(tmc_pkg::ADDR_COUNT, 32'h5A);
        $display("test readback done");
        // Forced matches on a stopped counter walk the set, toggle and clear non-PWM actions
        for (int i = 0; i < 4; i++)
        begin
            wr(tmc_pkg::ADDR_CONTROL, {24'h0, fctl[i]});
            repeat (2) @(posedge core_clk);
            chk({31'h0, compare_out_pin}, {31'h0, fpin[i]});
        end
        chk({31'h0, pin_override}, 32'h1);
        rd(tmc_pkg::ADDR_STATUS, 32'h0);
        rd(tmc_pkg::ADDR_COUNT, 32'h5A);
        $display("test force done");
        // Clear-on-match with toggle: period of compare plus one ticks
        wr(tmc_pkg::ADDR_COMPARE, 32'h05);
        wr(tmc_pkg::ADDR_COUNT, 32'h00);
        wr(tmc_pkg::ADDR_CONTROL, 32'h19);
        measure(60);
        near(tg, 10, 1);
        rd(tmc_pkg::ADDR_STATUS, 32'h1);
        wr(tmc_pkg::ADDR_CONTROL, 32'h00);
        $display("test clear_on_match done");
        // Count write right at the compare value must not match
        wr(tmc_pkg::ADDR_STATUS, 32'h3);
        wr(tmc_pkg::ADDR_CONTROL, 32'hA0);
        wr(tmc_pkg::ADDR_COMPARE, 32'h10);
        wr(tmc_pkg::ADDR_COUNT, 32'h80);
        wr(tmc_pkg::ADDR_CONTROL, 32'h31);
        wr(tmc_pkg::ADDR_COUNT, 32'h10);
        measure(100);
        near(hi, 0, 0);
        repeat (200) @(posedge core_clk);
        chk({31'h0, compare_out_pin}, 32'h1);
        rd(tmc_pkg::ADDR_STATUS, 32'h3);
        $display("test suppress done");
        wr(tmc_pkg::ADDR_CONTROL, 32'h00);
        // Prescaler codes 1 to 7, then the oscillator source undivided
        for (int i = 0; i < 8; i++)
        begin
            wr(tmc_pkg::ADDR_COUNT, 32'h00);
            async_sel <= (i == 7);
            wr(tmc_pkg::ADDR_CONTROL, (i == 7) ? 32'h1 : 32'(i + 1));
            repeat (16 * divs[i]) @(posedge core_clk);
            wr(tmc_pkg::ADDR_CONTROL, 32'h00);
            rd(tmc_pkg::ADDR_COUNT, 32'h0, 32'h0);
            near(int'(d[7:0]), (16 * divs[i] + 3) / divs[i], 2);
        end
        async_sel <= 1'b0;
        $display("test prescaler done");
        // Fast and phase correct PWM, both polarities, compare at TOP
        for (int i = 0; i < 6; i++)
        begin
            wr(tmc_pkg::ADDR_CONTROL, 32'h00);
            wr(tmc_pkg::ADDR_COUNT, 32'h00);
            wr(tmc_pkg::ADDR_COMPARE, {24'h0, pcmp[i]});
            wr(tmc_pkg::ADDR_STATUS, 32'h3);
            wr(tmc_pkg::ADDR_CONTROL, {24'h0, pctl[i]});
            repeat (600) @(posedge core_clk);
            measure(pwin[i]);
            near(hi, phi[i], ptol[i]);
            chk({31'h0, pin_override}, 32'h1);
            rd(tmc_pkg::ADDR_STATUS, 32'h2, 32'h2);
        end
        wr(tmc_pkg::ADDR_CONTROL, 32'h00);
        $display("test pwm done");
        report_and_stop();
    end
endmodule
`default_nettype wire
